// [pkg/ivm_params.svh]
// constants for the interrupt vector map: vector addresses and timing
`ifndef IVM_PARAMS_SVH
`define IVM_PARAMS_SVH
`define IVM_VEC_USB 16'hffe0
`define IVM_VEC_SCI 16'hffe2
`define IVM_VEC_I2C 16'hffe4
`define IVM_VEC_TIM_OVF 16'hffe6
`define IVM_VEC_TIM_OCMP 16'hffe8
`define IVM_VEC_TIM_ICAP 16'hffea
`define IVM_VEC_RSVD_A 16'hffec
`define IVM_VEC_EXT_PORTC 16'hffee
`define IVM_VEC_EXT_A 16'hfff0
`define IVM_VEC_EXT_B 16'hfff2
`define IVM_VEC_EXT_C 16'hfff4
`define IVM_VEC_EXT_RISE 16'hfff6
`define IVM_VEC_RSVD_B 16'hfff8
`define IVM_VEC_USB_RESUME 16'hfffa
`define IVM_VEC_TRAP 16'hfffc
`define IVM_VEC_RESET 16'hfffe
`define IVM_SRC_USB 4'h0
`define IVM_SRC_SCI 4'h1
`define IVM_SRC_I2C 4'h2
`define IVM_SRC_TIM_OVF 4'h3
`define IVM_SRC_TIM_OCMP 4'h4
`define IVM_SRC_TIM_ICAP 4'h5
`define IVM_SRC_EXT_PORTC 4'h6
`define IVM_SRC_EXT_A 4'h7
`define IVM_SRC_EXT_B 4'h8
`define IVM_SRC_EXT_C 4'h9
`define IVM_SRC_EXT_RISE 4'ha
`define IVM_SRC_USB_RESUME 4'hb
`define IVM_SRC_TRAP 4'hc
`define IVM_SRC_RESET 4'hd
`define IVM_SRC_NONE 4'hf
`define IVM_NUM_EXT 5
`define IVM_EXT_RISE_IDX 3
`define IVM_RST_OUT_NS 1000
`define IVM_CLK_PERIOD_NS 5
`define IVM_RST_OUT_CYC (`IVM_RST_OUT_NS / `IVM_CLK_PERIOD_NS)
`endif

// [pkg/ivm_pkg.sv]
// types for the interrupt vector map
package ivm_pkg;
   typedef enum logic [1:0] {IVM_RST_IDLE, IVM_RST_DRIVE, IVM_RST_WAIT}
      ivm_rst_state_t;
   typedef logic [15:0] ivm_addr_t;
   typedef logic [3:0] ivm_src_t;
endpackage : ivm_pkg

// [pkg/ivm_ext_if.sv]
// pending external interrupt lines between edge detector and mapper
`timescale 1ns/1ps
interface ivm_ext_if;
   logic [4:0] pend;
   logic [4:0] ack;
   modport det (output pend, input ack);
   modport map (input pend, output ack);
endinterface : ivm_ext_if

// [hdl/ivm_edge_det.sv]
// edge detectors for the five external interrupt pins
`timescale 1ns/1ps
`include "ivm_params.svh"
module ivm_edge_det
   import ivm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [4:0] pins,
   ivm_ext_if.det ext
);
   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] prev;
      logic [4:0] pend;
   } ivm_det_st_t;
   ivm_det_st_t st_q, st_d;
   logic [4:0] edge_hit;

   assign ext.pend = st_q.pend;

   always_comb begin
      st_d = st_q;
      st_d.s1 = pins;
      st_d.s2 = st_q.s1;
      st_d.prev = st_q.s2;
      // lines a,b,c and portc fall, the port d bit seven line rises
      edge_hit = st_q.prev & ~st_q.s2;
      edge_hit[`IVM_EXT_RISE_IDX] = ~st_q.prev[`IVM_EXT_RISE_IDX] &
         st_q.s2[`IVM_EXT_RISE_IDX];
      // a new edge in the ack cycle wins over the clear
      st_d.pend = (st_q.pend & ~ext.ack) | edge_hit;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule : ivm_edge_det

// [hdl/ivm_vector_map.sv]
// interrupt source arbitration and vector address mapping
`timescale 1ns/1ps
`include "ivm_params.svh"
// Summary of operation
// - each source owns a fixed two-byte slot; reset at FFFE, trap at FFFC
// - timer overflow vector is fetched from FFE6
// - timer output compare vector is fetched from FFE8
// - timer input capture vector is fetched from FFEA
// - leaving USB suspend raises an interrupt using vector FFFA
// - low reset pin is top priority and cannot be masked
// - reset pin is bidirectional; device can drive it low
// - port D bit 7 rising edge requests via FFF6
// - port D bits 5,4,3 falling edges drive lines a, b, c
// - port C bit 2 falling edge drives the portc line
module ivm_vector_map
   import ivm_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic RESET_PIN_I,
   output logic RESET_PIN_O,
   output logic RESET_PIN_OE,
   input wire logic RESET_REQ,
   output logic RESET_ACTIVE,
   input wire logic PORTD_BIT_SEVEN,
   input wire logic PORTD_BIT_FIVE,
   input wire logic PORTD_BIT_FOUR,
   input wire logic PORTD_BIT_THREE,
   input wire logic PORTC_BIT_TWO,
   input wire logic [4:0] EXT_IRQ_EN,
   input wire logic USB_IRQ,
   input wire logic SCI_IRQ,
   input wire logic I2C_IRQ,
   input wire logic TIM_OVF_IRQ,
   input wire logic TIM_OCMP_IRQ,
   input wire logic TIM_ICAP_IRQ,
   input wire logic USB_SUSPENDED,
   input wire logic TRAP_REQ,
   input wire logic IRQ_MASK,
   output logic IRQ_PENDING,
   input wire logic VEC_ACK,
   output logic [15:0] VEC_ADDR,
   output logic [3:0] VEC_SRC
);
   typedef struct packed {
      ivm_rst_state_t rst_st;
      logic [7:0] rst_cnt;
      logic rst_s1;
      logic rst_s2;
      logic susp_s1;
      logic susp_s2;
      logic susp_prev;
      logic resume_pend;
      logic [15:0] vec;
      logic [3:0] src;
   } ivm_map_st_t;

   ivm_map_st_t st_q, st_d;
   ivm_ext_if ext ();
   logic [4:0] ext_pins;
   logic [4:0] ext_req;
   ivm_src_t win;
   logic any_req;

   function automatic ivm_addr_t vec_of(input ivm_src_t s);
      case (s)
         `IVM_SRC_USB: vec_of = `IVM_VEC_USB;
         `IVM_SRC_SCI: vec_of = `IVM_VEC_SCI;
         `IVM_SRC_I2C: vec_of = `IVM_VEC_I2C;
         `IVM_SRC_TIM_OVF: vec_of = `IVM_VEC_TIM_OVF;
         `IVM_SRC_TIM_OCMP: vec_of = `IVM_VEC_TIM_OCMP;
         `IVM_SRC_TIM_ICAP: vec_of = `IVM_VEC_TIM_ICAP;
         `IVM_SRC_EXT_PORTC: vec_of = `IVM_VEC_EXT_PORTC;
         `IVM_SRC_EXT_A: vec_of = `IVM_VEC_EXT_A;
         `IVM_SRC_EXT_B: vec_of = `IVM_VEC_EXT_B;
         `IVM_SRC_EXT_C: vec_of = `IVM_VEC_EXT_C;
         `IVM_SRC_EXT_RISE: vec_of = `IVM_VEC_EXT_RISE;
         `IVM_SRC_USB_RESUME: vec_of = `IVM_VEC_USB_RESUME;
         `IVM_SRC_TRAP: vec_of = `IVM_VEC_TRAP;
         `IVM_SRC_RESET: vec_of = `IVM_VEC_RESET;
         default: vec_of = `IVM_VEC_RESET;
      endcase
   endfunction : vec_of

   // bit order: 0 line a, 1 line b, 2 line c, 3 rising, 4 portc
   assign ext_pins = {PORTC_BIT_TWO, PORTD_BIT_SEVEN, PORTD_BIT_THREE,
      PORTD_BIT_FOUR, PORTD_BIT_FIVE};

   ivm_edge_det u_det (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .pins(ext_pins),
      .ext(ext)
   );

   // a disabled line keeps its pending flag until enabled and acked
   assign ext_req = ext.pend & EXT_IRQ_EN;

   // fixed priority, highest first: reset, trap, resume, the external
   // lines, then the peripherals from the lowest vector address upward
   always_comb begin
      if (!st_q.rst_s2) begin
         win = `IVM_SRC_RESET;
      end else if (TRAP_REQ) begin
         // trap is a software interrupt, not maskable
         win = `IVM_SRC_TRAP;
      end else if (IRQ_MASK) begin
         win = `IVM_SRC_NONE;
      end else if (st_q.resume_pend) begin
         win = `IVM_SRC_USB_RESUME;
      end else if (ext_req[3]) begin
         win = `IVM_SRC_EXT_RISE;
      end else if (ext_req[0]) begin
         win = `IVM_SRC_EXT_A;
      end else if (ext_req[1]) begin
         win = `IVM_SRC_EXT_B;
      end else if (ext_req[2]) begin
         win = `IVM_SRC_EXT_C;
      end else if (ext_req[4]) begin
         win = `IVM_SRC_EXT_PORTC;
      end else if (USB_IRQ) begin
         win = `IVM_SRC_USB;
      end else if (SCI_IRQ) begin
         win = `IVM_SRC_SCI;
      end else if (I2C_IRQ) begin
         win = `IVM_SRC_I2C;
      end else if (TIM_OVF_IRQ) begin
         win = `IVM_SRC_TIM_OVF;
      end else if (TIM_OCMP_IRQ) begin
         win = `IVM_SRC_TIM_OCMP;
      end else if (TIM_ICAP_IRQ) begin
         win = `IVM_SRC_TIM_ICAP;
      end else begin
         win = `IVM_SRC_NONE;
      end
   end

   assign any_req = (win != `IVM_SRC_NONE);

   always_comb begin
      st_d = st_q;
      ext.ack = '0;
      st_d.rst_s1 = RESET_PIN_I;
      st_d.rst_s2 = st_q.rst_s1;
      // suspend comes from the usb side, so it is synchronised like a pin
      st_d.susp_s1 = USB_SUSPENDED;
      st_d.susp_s2 = st_q.susp_s1;
      st_d.susp_prev = st_q.susp_s2;
      st_d.vec = vec_of(win);
      st_d.src = win;
      if (VEC_ACK && any_req) begin
         case (win)
            `IVM_SRC_EXT_A: begin
               ext.ack[0] = 1'b1;
            end
            `IVM_SRC_EXT_B: begin
               ext.ack[1] = 1'b1;
            end
            `IVM_SRC_EXT_C: begin
               ext.ack[2] = 1'b1;
            end
            `IVM_SRC_EXT_RISE: begin
               ext.ack[3] = 1'b1;
            end
            `IVM_SRC_EXT_PORTC: begin
               ext.ack[4] = 1'b1;
            end
            `IVM_SRC_USB_RESUME: begin
               st_d.resume_pend = 1'b0;
            end
            default: ;
         endcase
      end
      // leaving suspend sets the flag after the ack so the set wins
      if (st_q.susp_prev && !st_q.susp_s2)
         st_d.resume_pend = 1'b1;
      // the pin driver pulls low for a fixed time, then waits for release
      // limitation: a request while the pin is held low from outside is
      // still taken; the drive then simply overlaps the external reset
      case (st_q.rst_st)
         IVM_RST_IDLE: begin
            if (RESET_REQ) begin
               st_d.rst_st = IVM_RST_DRIVE;
               st_d.rst_cnt = 8'(`IVM_RST_OUT_CYC - 1);
            end
         end
         IVM_RST_DRIVE: begin
            if (st_q.rst_cnt == 8'h00) begin
               st_d.rst_st = IVM_RST_WAIT;
            end else begin
               st_d.rst_cnt = st_q.rst_cnt - 8'h01;
            end
         end
         IVM_RST_WAIT: begin
            // avoid retriggering on our own low level still in sync chain
            if (st_q.rst_s2) st_d.rst_st = IVM_RST_IDLE;
         end
         default: st_d.rst_st = IVM_RST_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_q <= '0;
         st_q.rst_s1 <= 1'b1;
         st_q.rst_s2 <= 1'b1;
         st_q.vec <= `IVM_VEC_RESET;
         st_q.src <= `IVM_SRC_NONE;
         st_q.rst_st <= IVM_RST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // open drain: the data is always low, the enable alone decides
   assign RESET_PIN_O = 1'b0;
   assign RESET_PIN_OE = (st_q.rst_st != IVM_RST_DRIVE);
   assign RESET_ACTIVE = !st_q.rst_s2;
   assign IRQ_PENDING = any_req;
   assign VEC_ADDR = st_q.vec;
   assign VEC_SRC = st_q.src;
endmodule : ivm_vector_map

// [test/ivm_sva.sv]
// assertion checker on the vector map top ports
`timescale 1ns/1ps
`include "ivm_params.svh"
module ivm_sva (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic RESET_PIN_I,
   input wire logic RESET_PIN_O,
   input wire logic RESET_PIN_OE,
   input wire logic RESET_REQ,
   input wire logic RESET_ACTIVE,
   input wire logic TRAP_REQ,
   input wire logic [15:0] VEC_ADDR,
   input wire logic [3:0] VEC_SRC
);
   localparam int RST_CYC = `IVM_RST_OUT_CYC;
   logic [2:0] hi_q;
   logic [7:0] low_q;
   // quiet: pin high long enough that the synchroniser has settled
   wire quiet = hi_q == 3'h7;
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         hi_q <= 3'h0;
         low_q <= 8'h0;
      end else begin
         hi_q <= !RESET_PIN_I ? 3'h0 : hi_q + {2'h0, !quiet};
         low_q <= RESET_PIN_OE ? 8'h0 : low_q + 8'h1;
      end
   end
   function automatic logic [15:0] vec(input logic [3:0] s);
      vec = 16'hffe0 + {11'h0, s + 4'(s > 4'h5) + 4'(s > 4'ha), 1'b0};
   endfunction : vec
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   property p_rst;
      RESET_ACTIVE ##1 RESET_ACTIVE |-> VEC_SRC == 4'hd;
   endproperty
   a_rst: assert property (p_rst) else $error("reset lost");
   property p_trap; quiet && TRAP_REQ |=> VEC_SRC == 4'hc; endproperty
   a_trap: assert property (p_trap) else $error("no trap");
   property p_ovf; VEC_SRC == 4'h3 |-> VEC_ADDR == 16'hffe6; endproperty
   a_ovf: assert property (p_ovf) else $error("ovf vector");
   property p_ocmp; VEC_SRC == 4'h4 |-> VEC_ADDR == 16'hffe8; endproperty
   a_ocmp: assert property (p_ocmp) else $error("ocmp vector");
   property p_icap; VEC_SRC == 4'h5 |-> VEC_ADDR == 16'hffea; endproperty
   a_icap: assert property (p_icap) else $error("icap vector");
   property p_map; VEC_SRC != 4'hf |-> VEC_ADDR == vec(VEC_SRC); endproperty
   a_map: assert property (p_map) else $error("bad slot");
   property p_rsvd; VEC_ADDR != 16'hffec && VEC_ADDR != 16'hfff8; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved slot");
   property p_drv;
      quiet && RESET_PIN_OE && $rose(RESET_REQ) |=> !RESET_PIN_OE;
   endproperty
   a_drv: assert property (p_drv) else $error("pin not driven");
   property p_len; $rose(RESET_PIN_OE) |-> low_q == 8'(RST_CYC); endproperty
   a_len: assert property (p_len) else $error("drive length");
   property p_pin; !RESET_PIN_OE |-> !RESET_PIN_O; endproperty
   a_pin: assert property (p_pin) else $error("pin data high");
   c_drv: cover property ($rose(RESET_PIN_OE));
   c_resume: cover property (VEC_SRC == 4'hb);
   c_trap: cover property (VEC_SRC == 4'hc);
   c_rise: cover property (VEC_SRC == 4'ha);
endmodule : ivm_sva

// [test/ivm_cpu_model.sv]
// cpu side model that acknowledges and records the winning source
`timescale 1ns/1ps
module ivm_cpu_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic slow,
   input wire logic pending,
   input wire logic [3:0] vec_src,
   output logic ack,
   output logic [3:0] got_src
);
   logic hold_q;
   logic [2:0] wait_q;
   // hold_q skips one edge so a just-cleared flag is not taken twice
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack <= 1'b0;
         hold_q <= 1'b0;
         wait_q <= 3'h0;
         got_src <= 4'hf;
      end else if (ack) begin
         ack <= 1'b0;
         hold_q <= 1'b1;
         wait_q <= 3'h0;
         got_src <= vec_src;
      end else if (hold_q) begin
         hold_q <= 1'b0;
      end else if (pending && vec_src != 4'hf) begin
         wait_q <= wait_q + 3'h1;
         ack <= !slow || wait_q == 3'h7;
      end
   end
endmodule : ivm_cpu_model

// [test/tb.sv]
// self-checking bench for the interrupt vector map
`timescale 1ns/1ps
module tb;
   logic REF_CLK = 1'b0, RST_B = 1'b0, ext_rst = 1'b1, req = 1'b0;
   logic susp = 1'b0, trap = 1'b0, mask = 1'b0, slow = 1'b0;
   logic [4:0] pins = 5'h17, en = 5'h1f;
   logic [5:0] isrc = 6'h0;
   logic oe_b, ack, pend, act;
   logic [3:0] src, got;
   logic [3:0] ecode [5] = '{4'h7, 4'h8, 4'h9, 4'ha, 4'h6};
   int mismatches = 0, checks_done = 0, cyc = 0, i;
   wire rst_pin = oe_b ? ext_rst : 1'b0;
   always #2.5 REF_CLK = ~REF_CLK;
   ivm_vector_map DUT (.REF_CLK(REF_CLK), .RST_B(RST_B), .RESET_PIN_I(rst_pin),
      .RESET_PIN_O(), .RESET_PIN_OE(oe_b), .RESET_REQ(req),
      .RESET_ACTIVE(act), .PORTD_BIT_SEVEN(pins[3]), .PORTD_BIT_FIVE(pins[0]),
      .PORTD_BIT_FOUR(pins[1]), .PORTD_BIT_THREE(pins[2]),
      .PORTC_BIT_TWO(pins[4]), .EXT_IRQ_EN(en), .USB_IRQ(isrc[0]),
      .SCI_IRQ(isrc[1]), .I2C_IRQ(isrc[2]), .TIM_OVF_IRQ(isrc[3]),
      .TIM_OCMP_IRQ(isrc[4]), .TIM_ICAP_IRQ(isrc[5]), .USB_SUSPENDED(susp),
      .TRAP_REQ(trap), .IRQ_MASK(mask), .IRQ_PENDING(pend), .VEC_ACK(ack),
      .VEC_ADDR(), .VEC_SRC(src));
   ivm_cpu_model cpu (.clk(REF_CLK), .rst_b(RST_B), .slow(slow),
      .pending(pend), .vec_src(src), .ack(ack), .got_src(got));
   function automatic logic [3:0] first(input logic [5:0] v);
      first = 4'hf;
      for (int k = 5; k >= 0; k--) if (v[k]) first = 4'(k);
   endfunction : first
   task chk(input logic [3:0] seen, input logic [3:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task wait_got(input logic [3:0] code);
      for (int n = 0; n < 40 && got !== code; n++) @(negedge REF_CLK);
      chk(got, code);
   endtask : wait_got
   task end_sim;
      if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   // ceiling well above the roughly 500 cycles the sequence needs
   always @(posedge REF_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         mismatches++;
         end_sim();
      end
   end
   initial begin
      void'($urandom(32'h37c7));
      repeat (8) @(posedge REF_CLK);
      RST_B <= 1'b1;
      for (i = 0; i < 26; i++) begin
         @(posedge REF_CLK);
         isrc <= i < 6 ? 6'h1 << i : 6'($urandom);
         slow <= i[0];
         repeat (3) @(negedge REF_CLK);
         chk(src, first(isrc));
      end
      @(posedge REF_CLK);
      mask <= 1'b1;
      isrc <= 6'h3f;
      repeat (3) @(negedge REF_CLK);
      chk({3'h0, pend}, 4'h0);
      @(posedge REF_CLK);
      trap <= 1'b1;
      repeat (3) @(negedge REF_CLK);
      chk(src, 4'hc);
      @(posedge REF_CLK);
      ext_rst <= 1'b0;
      repeat (6) @(negedge REF_CLK);
      chk(src, 4'hd);
      chk({3'h0, act}, 4'h1);
      @(posedge REF_CLK);
      {ext_rst, trap, mask, isrc, susp} <= {1'b1, 8'h0, 1'b1};
      repeat (12) @(posedge REF_CLK);
      susp <= 1'b0;
      wait_got(4'hb);
      for (i = 0; i < 5; i++) begin
         @(posedge REF_CLK);
         pins <= pins ^ (5'h1 << i);
         wait_got(ecode[i]);
         @(posedge REF_CLK);
         pins <= 5'h17;
      end
      repeat (6) @(negedge REF_CLK);
      chk(src, 4'hf);
      @(posedge REF_CLK);
      en <= 5'h1e;
      pins <= 5'h16;
      repeat (8) @(negedge REF_CLK);
      chk({3'h0, pend}, 4'h0);
      chk(src, 4'hf);
      @(posedge REF_CLK);
      en <= 5'h1f;
      pins <= 5'h17;
      wait_got(4'h7);
      @(posedge REF_CLK);
      req <= 1'b1;
      @(posedge REF_CLK);
      req <= 1'b0;
      repeat (150) @(negedge REF_CLK);
      chk({3'h0, oe_b}, 4'h0);
      chk(src, 4'hd);
      repeat (80) @(negedge REF_CLK);
      chk({3'h0, oe_b}, 4'h1);
      end_sim();
   end
endmodule : tb
bind ivm_vector_map ivm_sva u_sva (.*);
